// [src/dab_pkg.sv]
// shared constants and types of the block-averaging converter logic
package dab_pkg;

	// core clock, in kHz
	localparam int CLK_KHZ = 250000;

	// internal pacing of the extra samples in a burst
	localparam int WIDE_PACE_KSPS = 3000;
	localparam int NARROW_PACE_KSPS = 4000;
	localparam int WIDE_PACE_CYC_INT = (CLK_KHZ + WIDE_PACE_KSPS - 1) / WIDE_PACE_KSPS;
	localparam int NARROW_PACE_CYC_INT = (CLK_KHZ + NARROW_PACE_KSPS - 1) / NARROW_PACE_KSPS;
	localparam int PACE_W = 7;
	localparam logic [PACE_W-1:0] WIDE_PACE_CYCLES = PACE_W'(WIDE_PACE_CYC_INT);
	localparam logic [PACE_W-1:0] NARROW_PACE_CYCLES = PACE_W'(NARROW_PACE_CYC_INT);

	// power-up settling interval
	localparam int SETTLE_US = 5;
	localparam int SETTLE_CYC_INT = SETTLE_US * CLK_KHZ / 1000;
	localparam int SETTLE_W = 12;
	localparam logic [SETTLE_W-1:0] SETTLE_CYCLES = SETTLE_W'(SETTLE_CYC_INT);

	// data widths
	localparam int SAMPLE_W = 16;
	localparam int NARROW_SAMPLE_W = 14;
	localparam int SUM_W = 21;
	localparam int OUT_W = 18;
	localparam int CNT_W = 6;
	localparam int BITS_W = 5;

	// left-alignment of a result inside the output shifter
	localparam logic [2:0] ALIGN_EXTRA_WIDE = 3'h0;
	localparam logic [2:0] ALIGN_NATIVE_WIDE = 3'h2;
	localparam logic [2:0] ALIGN_EXTRA_NARROW = 3'h2;
	localparam logic [2:0] ALIGN_NATIVE_NARROW = 3'h4;
	localparam logic [BITS_W-1:0] WIDE_NATIVE_BITS = 5'h10;
	localparam logic [BITS_W-1:0] WIDE_EXTRA_BITS = 5'h12;
	localparam logic [BITS_W-1:0] NARROW_NATIVE_BITS = 5'h0E;
	localparam logic [BITS_W-1:0] NARROW_EXTRA_BITS = 5'h10;

	// averaging ratio field: code k selects n = 2**k
	localparam logic [2:0] RATIO_OFF = 3'h0;
	localparam logic [2:0] RATIO_MAX_CODE = 3'h5;

	// reset values of the primary setup register
	localparam logic [2:0] RATIO_RST = 3'h0;
	localparam logic STYLE_RST = 1'h0;
	localparam logic EXTRA_RST = 1'h0;
	localparam logic STYLE_BLOCK = 1'h0;

	typedef enum logic [2:0] {
		DAB_IDLE,
		DAB_START,
		DAB_CONVERT,
		DAB_PACE,
		DAB_FINISH
	} dab_state_t;

endpackage : dab_pkg

// [src/dab_sync.sv]
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ns
module dab_sync #(
	parameter int WIDTH = 1
) (
	// clock and control
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	// levels
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	always_comb begin
		next_meta = i_clk_en ? i_async : meta;
		next_sync = i_clk_en ? meta : o_sync;
	end

	// idle-high pins reset to one so no false edge follows reset
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			meta <= '1;
			o_sync <= '1;
		end else begin
			meta <= next_meta;
			o_sync <= next_sync;
		end
	end
endmodule : dab_sync

// [src/dab_accum.sv]
// one channel's burst accumulator with divide and precision format
`timescale 1ns/1ns
module dab_accum
	import dab_pkg::*;
(
	// clock and control
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	// accumulate
	input wire logic i_clear,
	input wire logic i_add,
	input wire logic signed [SAMPLE_W-1:0] i_sample,
	// format
	input wire logic [2:0] i_shift,
	input wire logic i_extra,
	output logic [OUT_W-1:0] o_average
);
	logic signed [SUM_W-1:0] sum;
	logic signed [SUM_W-1:0] next_sum;
	logic signed [SUM_W+1:0] scaled;

	always_comb begin
		next_sum = sum;
		if (i_clk_en) begin
			if (i_clear) begin
				next_sum = '0;
			end else if (i_add) begin
				next_sum = sum + SUM_W'(i_sample);
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			sum <= '0;
		end else begin
			sum <= next_sum;
		end
	end

	// sum of n samples divided by n = arithmetic shift by log2(n)
	always_comb begin
		if (i_extra) begin
			scaled = {sum, 2'b00} >>> i_shift;
		end else begin
			scaled = (SUM_W+2)'(sum) >>> i_shift;
		end
		o_average = scaled[OUT_W-1:0];
	end
endmodule : dab_accum

// [src/dab_avg.sv]
// top of the dual-channel block-averaging and serial read-out logic
// Functional notes
// - style bit and ratio field of the setup register choose oversampling behaviour
// - block averaging only with style 0 and a valid nonzero ratio
// - a written ratio takes effect two cycles after the write
// - sum n samples per channel, divide the sum by n
// - averaged output is 16 bits wide variant, 14 bits narrow variant
// - only the first conversion starts on chip select fall; rest internal
// - extra samples paced at 3 MSPS wide, 4 MSPS narrow
// - averaged result is read on the serial access after the burst
// - samples of a finished average are discarded before the next burst
// - ratio codes decode to 2, 4, 8, 16, 32; zero disables
// - output rate falls by the ratio; host may slow its serial clock
// - extra-precision bit widens the averaged output
// - chip select and accesses during settling leave no lasting effect; here a fall during settling starts a burst
// - extra precision gives 18 bits wide, 16 bits narrow, shifted out fully
// - results leave most significant bit first, twos complement
`timescale 1ns/1ns
module dab_avg
	import dab_pkg::*;
(
	// clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	// primary setup register fields
	input wire logic i_setup_write,
	input wire logic i_averaging_style_select,
	input wire logic [2:0] i_averaging_ratio_field,
	input wire logic i_extra_precision_select,
	// variant strap pin, high for the narrow variant
	input wire logic i_variant_narrow,
	// serial pins
	input wire logic i_cs_n,
	input wire logic i_sclk,
	output logic o_sdo_a,
	output logic o_sdo_b,
	// converter core
	output logic o_conv_start,
	input wire logic i_conv_done,
	input wire logic [SAMPLE_W-1:0] i_conv_a,
	input wire logic [SAMPLE_W-1:0] i_conv_b,
	// status
	output logic o_busy,
	output logic o_results_settled
);
	logic cs_s;
	logic sclk_s;
	logic narrow_s;
	logic cs_q;
	logic sclk_q;
	logic next_cs_q;
	logic next_sclk_q;
	logic cs_fall;
	logic sclk_fall;

	dab_sync #(
		.WIDTH(3)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_clk_en(i_clk_en),
		.i_async({i_cs_n, i_sclk, i_variant_narrow}),
		.o_sync({cs_s, sclk_s, narrow_s})
	);

	always_comb begin
		next_cs_q = i_clk_en ? cs_s : cs_q;
		next_sclk_q = i_clk_en ? sclk_s : sclk_q;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			cs_q <= 1'b1;
			sclk_q <= 1'b1;
		end else begin
			cs_q <= next_cs_q;
			sclk_q <= next_sclk_q;
		end
	end

	assign cs_fall = i_clk_en && cs_q && !cs_s;
	assign sclk_fall = i_clk_en && sclk_q && !sclk_s;

	// setup register; ratio goes through two stages
	logic style;
	logic extra;
	logic [2:0] ratio_stage;
	logic [2:0] ratio;
	logic next_style;
	logic next_extra;
	logic [2:0] next_ratio_stage;
	logic [2:0] next_ratio;

	always_comb begin
		next_style = style;
		next_extra = extra;
		next_ratio_stage = ratio_stage;
		next_ratio = ratio;
		if (i_clk_en) begin
			next_ratio = ratio_stage;
			if (i_setup_write) begin
				next_style = i_averaging_style_select;
				next_extra = i_extra_precision_select;
				next_ratio_stage = i_averaging_ratio_field;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			style <= STYLE_RST;
			extra <= EXTRA_RST;
			ratio_stage <= RATIO_RST;
			ratio <= RATIO_RST;
		end else begin
			style <= next_style;
			extra <= next_extra;
			ratio_stage <= next_ratio_stage;
			ratio <= next_ratio;
		end
	end

	// burst sequencer
	dab_state_t state;
	dab_state_t next_state;
	logic [PACE_W-1:0] pace_cnt;
	logic [PACE_W-1:0] next_pace_cnt;
	logic [CNT_W-1:0] sample_cnt;
	logic [CNT_W-1:0] next_sample_cnt;
	logic [2:0] burst_shift;
	logic [2:0] next_burst_shift;
	logic burst_extra;
	logic next_burst_extra;
	logic burst_narrow;
	logic next_burst_narrow;
	logic [OUT_W-1:0] result_a;
	logic [OUT_W-1:0] result_b;
	logic [BITS_W-1:0] result_bits;
	logic [OUT_W-1:0] next_result_a;
	logic [OUT_W-1:0] next_result_b;
	logic [BITS_W-1:0] next_result_bits;
	logic avg_valid;
	logic acc_add;
	logic acc_clear;
	logic [PACE_W-1:0] pace_limit;
	logic [CNT_W-1:0] sample_target;
	logic [2:0] align;
	logic [SAMPLE_W-1:0] sample_a;
	logic [SAMPLE_W-1:0] sample_b;
	logic [OUT_W-1:0] avg [2];

	assign avg_valid = (style == STYLE_BLOCK) && (ratio != RATIO_OFF)
		&& (ratio <= RATIO_MAX_CODE);
	assign pace_limit = burst_narrow ? NARROW_PACE_CYCLES : WIDE_PACE_CYCLES;
	assign sample_target = CNT_W'(1) << burst_shift;
	assign o_conv_start = (state == DAB_START);
	assign o_busy = (state != DAB_IDLE);
	assign acc_add = (state == DAB_CONVERT) && i_conv_done;
	assign acc_clear = (state == DAB_FINISH);

	// narrow samples arrive in the low 14 bits, sign extended here
	always_comb begin
		if (burst_narrow) begin
			sample_a = {{(SAMPLE_W-NARROW_SAMPLE_W){i_conv_a[NARROW_SAMPLE_W-1]}},
				i_conv_a[NARROW_SAMPLE_W-1:0]};
			sample_b = {{(SAMPLE_W-NARROW_SAMPLE_W){i_conv_b[NARROW_SAMPLE_W-1]}},
				i_conv_b[NARROW_SAMPLE_W-1:0]};
		end else begin
			sample_a = i_conv_a;
			sample_b = i_conv_b;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			dab_accum u_accum (
				.i_ref_clk(i_ref_clk),
				.i_sys_rst(i_sys_rst),
				.i_clk_en(i_clk_en),
				.i_clear(acc_clear),
				.i_add(acc_add),
				.i_sample(ch == 0 ? sample_a : sample_b),
				.i_shift(burst_shift),
				.i_extra(burst_extra),
				.o_average(avg[ch])
			);
		end
	endgenerate

	always_comb begin
		if (burst_narrow) begin
			align = burst_extra ? ALIGN_EXTRA_NARROW : ALIGN_NATIVE_NARROW;
		end else begin
			align = burst_extra ? ALIGN_EXTRA_WIDE : ALIGN_NATIVE_WIDE;
		end
	end

	always_comb begin
		next_state = state;
		next_pace_cnt = pace_cnt;
		next_sample_cnt = sample_cnt;
		next_burst_shift = burst_shift;
		next_burst_extra = burst_extra;
		next_burst_narrow = burst_narrow;
		next_result_a = result_a;
		next_result_b = result_b;
		next_result_bits = result_bits;
		if (i_clk_en) begin
			case (state)
				DAB_IDLE: begin
					if (cs_fall) begin
						next_burst_shift = avg_valid ? ratio : RATIO_OFF;
						next_burst_extra = avg_valid && extra;
						next_burst_narrow = narrow_s;
						next_sample_cnt = '0;
						next_state = DAB_START;
					end
				end
				DAB_START: begin
					next_pace_cnt = PACE_W'(1);
					next_state = DAB_CONVERT;
				end
				DAB_CONVERT: begin
					if (pace_cnt != '1) begin
						next_pace_cnt = pace_cnt + PACE_W'(1);
					end
					if (i_conv_done) begin
						next_sample_cnt = sample_cnt + CNT_W'(1);
						if (CNT_W'(sample_cnt + CNT_W'(1)) == sample_target) begin
							next_state = DAB_FINISH;
						end else begin
							next_state = DAB_PACE;
						end
					end
				end
				DAB_PACE: begin
					if (pace_cnt != '1) begin
						next_pace_cnt = pace_cnt + PACE_W'(1);
					end
					if (pace_cnt >= pace_limit - PACE_W'(1)) begin
						next_state = DAB_START;
					end
				end
				DAB_FINISH: begin
					// left-align so the shifter always sends bit 17 first
					next_result_a = avg[0] << align;
					next_result_b = avg[1] << align;
					if (burst_narrow) begin
						next_result_bits = burst_extra ? NARROW_EXTRA_BITS
							: NARROW_NATIVE_BITS;
					end else begin
						next_result_bits = burst_extra ? WIDE_EXTRA_BITS
							: WIDE_NATIVE_BITS;
					end
					next_state = DAB_IDLE;
				end
				default: begin
					next_state = DAB_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state <= DAB_IDLE;
			pace_cnt <= '0;
			sample_cnt <= '0;
			burst_shift <= RATIO_OFF;
			burst_extra <= 1'b0;
			burst_narrow <= 1'b0;
			result_a <= '0;
			result_b <= '0;
			result_bits <= WIDE_NATIVE_BITS;
		end else begin
			state <= next_state;
			pace_cnt <= next_pace_cnt;
			sample_cnt <= next_sample_cnt;
			burst_shift <= next_burst_shift;
			burst_extra <= next_burst_extra;
			burst_narrow <= next_burst_narrow;
			result_a <= next_result_a;
			result_b <= next_result_b;
			result_bits <= next_result_bits;
		end
	end

	// serial shifter: the held result leaves during the next frame
	logic [OUT_W-1:0] shift_a;
	logic [OUT_W-1:0] shift_b;
	logic [BITS_W-1:0] bits_left;
	logic [OUT_W-1:0] next_shift_a;
	logic [OUT_W-1:0] next_shift_b;
	logic [BITS_W-1:0] next_bits_left;
	logic next_sdo_a;
	logic next_sdo_b;

	always_comb begin
		next_shift_a = shift_a;
		next_shift_b = shift_b;
		next_bits_left = bits_left;
		if (i_clk_en) begin
			if (cs_fall) begin
				next_shift_a = result_a;
				next_shift_b = result_b;
				next_bits_left = result_bits;
			end else if (cs_s) begin
				next_bits_left = '0;
			end else if (sclk_fall && bits_left != '0) begin
				next_shift_a = shift_a << 1;
				next_shift_b = shift_b << 1;
				next_bits_left = bits_left - BITS_W'(1);
			end
		end
		next_sdo_a = (next_bits_left != '0) && next_shift_a[OUT_W-1];
		next_sdo_b = (next_bits_left != '0) && next_shift_b[OUT_W-1];
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			shift_a <= '0;
			shift_b <= '0;
			bits_left <= '0;
			o_sdo_a <= 1'b0;
			o_sdo_b <= 1'b0;
		end else begin
			shift_a <= next_shift_a;
			shift_b <= next_shift_b;
			bits_left <= next_bits_left;
			o_sdo_a <= next_sdo_a;
			o_sdo_b <= next_sdo_b;
		end
	end

	// settling only flags results; nothing else is gated by it
	logic [SETTLE_W-1:0] settle_cnt;
	logic [SETTLE_W-1:0] next_settle_cnt;
	logic next_settled;

	always_comb begin
		next_settle_cnt = settle_cnt;
		if (i_clk_en && settle_cnt != SETTLE_CYCLES) begin
			next_settle_cnt = settle_cnt + SETTLE_W'(1);
		end
		next_settled = (next_settle_cnt == SETTLE_CYCLES);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			settle_cnt <= '0;
			o_results_settled <= 1'b0;
		end else begin
			settle_cnt <= next_settle_cnt;
			o_results_settled <= next_settled;
		end
	end
endmodule : dab_avg

// [test/dab_core_model.sv]
// converter core stand-in answering each sample request of a burst
`timescale 1ns/1ns
module dab_core_model
	import dab_pkg::*;
(
	// clock and requests
	input wire logic i_ref_clk,
	input wire logic i_conv_start,
	input wire logic i_busy,
	input wire logic [SAMPLE_W-1:0] i_base,
	// answers
	output logic o_done,
	output logic [SAMPLE_W-1:0] o_a,
	output logic [SAMPLE_W-1:0] o_b
);
	int wait_cnt = 0;
	logic [SAMPLE_W-1:0] j = '0;
	initial begin
		o_done = 1'b0;
		o_a = '0;
		o_b = '0;
	end
	// data lines toggle outside the valid cycle so stale values never match
	always @(posedge i_ref_clk) begin
		o_done <= 1'b0;
		o_a <= ~o_a;
		o_b <= ~o_b;
		wait_cnt <= i_conv_start ? 10 : (wait_cnt > 0 ? wait_cnt - 1 : 0);
		if (!i_busy) j <= '0;
		if (!i_conv_start && wait_cnt == 1) begin
			o_done <= 1'b1;
			o_a <= i_base + j;
			o_b <= -(i_base + j);
			j <= j + 16'h0001;
		end
	end
endmodule : dab_core_model

// [test/dab_avg_properties.sv]
// concurrent checks on the averaging block ports
`timescale 1ns/1ns
module dab_avg_properties
	import dab_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// inputs watched
	input wire logic i_cs_n,
	input wire logic i_variant_narrow,
	// outputs watched
	input wire logic o_sdo_a,
	input wire logic o_sdo_b,
	input wire logic o_conv_start,
	input wire logic o_busy,
	input wire logic o_results_settled
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	logic [7:0] gap;
	logic [7:0] next_gap;
	logic seen;
	logic next_seen;
	logic [11:0] up;
	logic [11:0] next_up;
	// counters saturate so long idle gaps cannot wrap into a false failure
	always_comb begin
		next_gap = o_conv_start ? 8'h01 : (gap == 8'hFF ? gap : gap + 8'h01);
		next_seen = o_busy && (seen || o_conv_start);
		next_up = (up == 12'hFFF) ? up : up + 12'h001;
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			gap <= 8'h00;
			seen <= 1'b0;
			up <= 12'h000;
		end else begin
			gap <= next_gap;
			seen <= next_seen;
			up <= next_up;
		end
	end
	property p_start_in_burst;
		o_conv_start |-> o_busy;
	endproperty
	a_start_in_burst: assert property (p_start_in_burst) else $error("start outside burst");
	property p_start_pulse;
		o_conv_start |=> !o_conv_start;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start longer than a cycle");
	property p_pace_wide;
		o_conv_start && seen && !i_variant_narrow |-> gap >= 8'd84;
	endproperty
	a_pace_wide: assert property (p_pace_wide) else $error("wide pace too fast");
	property p_pace_narrow;
		o_conv_start && seen && i_variant_narrow |-> gap >= 8'd63;
	endproperty
	a_pace_narrow: assert property (p_pace_narrow) else $error("narrow pace too fast");
	property p_burst_from_cs;
		$rose(o_busy) |-> o_conv_start && $past(!i_cs_n, 2);
	endproperty
	a_burst_from_cs: assert property (p_burst_from_cs) else $error("burst without select");
	property p_sdo_quiet;
		i_cs_n [*4] |-> !o_sdo_a && !o_sdo_b;
	endproperty
	a_sdo_quiet: assert property (p_sdo_quiet) else $error("data out while deselected");
	property p_settle_late;
		$rose(o_results_settled) |-> up >= 12'd1248;
	endproperty
	a_settle_late: assert property (p_settle_late) else $error("settled flag too early");
	property p_settle_holds;
		o_results_settled |=> o_results_settled;
	endproperty
	a_settle_holds: assert property (p_settle_holds) else $error("settled flag dropped");
	c_paced: cover property (o_conv_start && seen);
	c_narrow: cover property (o_conv_start && i_variant_narrow);
	c_settled: cover property ($rose(o_results_settled));
endmodule : dab_avg_properties
bind dab_avg dab_avg_properties u_props (.i_ref_clk, .i_sys_rst, .i_cs_n, .i_variant_narrow,
	.o_sdo_a, .o_sdo_b, .o_conv_start, .o_busy, .o_results_settled);

// [test/testbench.sv]
// self-checking bench for the block-averaging logic
`timescale 1ns/1ns
module testbench
	import dab_pkg::*;
;
	logic i_ref_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_setup_write = 1'b0;
	logic style = 1'b0;
	logic [2:0] ratio = 3'h0;
	logic extra = 1'b0;
	logic narrow = 1'b0;
	logic clk_en = 1'b1;
	logic i_cs_n = 1'b1;
	logic i_sclk = 1'b0;
	logic o_sdo_a, o_sdo_b, o_conv_start, i_conv_done, o_busy, o_results_settled;
	logic [SAMPLE_W-1:0] i_conv_a, i_conv_b;
	logic [SAMPLE_W-1:0] base = 16'h0040;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int starts = 0;
	dab_avg uut (.i_ref_clk, .i_sys_rst, .i_clk_en(clk_en), .i_setup_write,
		.i_averaging_style_select(style), .i_averaging_ratio_field(ratio),
		.i_extra_precision_select(extra), .i_variant_narrow(narrow), .i_cs_n, .i_sclk,
		.o_sdo_a, .o_sdo_b, .o_conv_start, .i_conv_done, .i_conv_a, .i_conv_b, .o_busy,
		.o_results_settled);
	dab_core_model u_core (.i_ref_clk, .i_conv_start(o_conv_start), .i_busy(o_busy),
		.i_base(base), .o_done(i_conv_done), .o_a(i_conv_a), .o_b(i_conv_b));
	initial begin
		forever #2 i_ref_clk = ~i_ref_clk;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// bursts of ratio 32 bound the run; this ceiling leaves ample margin
	always @(posedge i_ref_clk) begin
		cycles++;
		if (o_conv_start === 1'b1) starts++;
		if (cycles == 60000) begin
			errors++;
			tally_and_finish();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask : tick
	task automatic check(input logic [OUT_W-1:0] got, input logic [OUT_W-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	// sclk stands low outside frames; host samples on its rising edge
	task automatic host_read(input int nb, output logic [OUT_W-1:0] ra,
		output logic [OUT_W-1:0] rb);
		ra = '0;
		rb = '0;
		i_cs_n = 1'b0;
		tick(8);
		for (int i = 0; i < nb; i++) begin
			i_sclk = 1'b1;
			ra = {ra[OUT_W-2:0], o_sdo_a};
			rb = {rb[OUT_W-2:0], o_sdo_b};
			tick(8);
			i_sclk = 1'b0;
			tick(8);
		end
		i_cs_n = 1'b1;
		tick(4);
	endtask : host_read
	task automatic wait_idle();
		for (int i = 0; i < 4000 && o_busy !== 1'b0; i++) tick(1);
		check({17'h0, o_busy}, 18'h0);
	endtask : wait_idle
	task automatic setup(input logic s, input logic [2:0] k, input logic e);
		style = s;
		ratio = k;
		extra = e;
		i_setup_write = 1'b1;
		tick(1);
		i_setup_write = 1'b0;
		tick(2);
	endtask : setup
	task automatic t_settle();
		logic [OUT_W-1:0] ra, rb;
		check({17'h0, o_results_settled}, 18'h0);
		host_read(16, ra, rb);
		wait_idle();
		for (int i = 0; i < 2000 && o_results_settled !== 1'b1; i++) tick(1);
		check({17'h0, o_results_settled}, 18'h1);
		$display("test settle done");
	endtask : t_settle
	task automatic t_rewrite();
		logic [OUT_W-1:0] ra, rb;
		ratio = 3'h5;
		i_setup_write = 1'b1;
		tick(1);
		ratio = 3'h2;
		tick(1);
		i_setup_write = 1'b0;
		tick(2);
		starts = 0;
		host_read(16, ra, rb);
		wait_idle();
		check(OUT_W'(starts), 18'h4);
		$display("test rewrite done");
	endtask : t_rewrite
	// enable low: a whole frame must go unseen, no burst, no data
	task automatic t_freeze();
		logic [OUT_W-1:0] ra, rb;
		clk_en = 1'b0;
		starts = 0;
		host_read(16, ra, rb);
		check(OUT_W'(starts), 18'h0);
		check(ra, 18'h0);
		check({17'h0, o_busy}, 18'h0);
		clk_en = 1'b1;
		tick(4);
		check({17'h0, o_busy}, 18'h0);
		$display("test freeze done");
	endtask : t_freeze
	task automatic t_avg(input logic s, input logic [2:0] k, input logic e, input logic nar,
		input logic [SAMPLE_W-1:0] bs);
		logic [OUT_W-1:0] ra, rb, mask;
		int n, nb, va, vb;
		logic v;
		v = (s == 1'b0) && (k >= 3'h1) && (k <= RATIO_MAX_CODE);
		n = v ? (1 << k) : 1;
		nb = (nar ? 14 : 16) + ((v && e) ? 2 : 0);
		va = (v && e) ? 4 * int'(bs) + 2 * (n - 1) : int'(bs) + (n - 1) / 2;
		vb = (v && e) ? -va : -int'(bs) - n / 2;
		mask = OUT_W'((1 << nb) - 1);
		narrow = nar;
		base = bs;
		setup(s, k, e);
		tick(4);
		starts = 0;
		host_read(nb, ra, rb);
		wait_idle();
		check(OUT_W'(starts), OUT_W'(n));
		host_read(nb, ra, rb);
		wait_idle();
		check(ra, OUT_W'(va) & mask);
		check(rb, OUT_W'(vb) & mask);
		$display("test avg s=%0d k=%0d e=%0d narrow=%0d done", s, k, e, nar);
	endtask : t_avg
	initial begin
		tick(3);
		i_sys_rst = 1'b0;
		t_settle();
		for (int k = 0; k < 8; k++) t_avg(1'b0, 3'(k), 1'b0, 1'b0, 16'h0040 + 16'(k));
		t_avg(1'b0, 3'h2, 1'b1, 1'b0, 16'h0123);
		t_avg(1'b0, 3'h5, 1'b1, 1'b0, 16'h0A05);
		t_avg(1'b1, 3'h3, 1'b1, 1'b0, 16'h0077);
		t_avg(1'b0, 3'h0, 1'b1, 1'b1, 16'h0155);
		t_avg(1'b0, 3'h1, 1'b0, 1'b1, 16'h0031);
		t_avg(1'b0, 3'h5, 1'b1, 1'b1, 16'h0202);
		t_freeze();
		t_rewrite();
		tally_and_finish();
	end
endmodule : testbench
